// ===== verilog/mhb_pkg.sv
// Package for the multimode host bus interface: modes, states, carriers.
// Assumes a single 20 MHz core clock; all bus pins sampled synchronously.
package mhb_pkg;
   localparam int          CLK_PERIOD_NS  = 50;
   localparam int          DATA_W         = 16;
   localparam int          ADDR_W         = 8;
   localparam int          FIFO_DEPTH     = 8;
   localparam int          BURST_DEF      = 1;
   localparam logic [15:0] LEN_RST        = 16'h0000;
   localparam int          STRAP_ALE_BIT  = 1;
   localparam int          STRAP_CLE_BIT  = 0;

   typedef enum logic [1:0] {
      MHB_SRAM,
      MHB_NOR,
      MHB_MUX
   } mhb_mode_t;

   typedef enum logic [1:0] {
      MHB_DMA_IDLE,
      MHB_DMA_REQ,
      MHB_DMA_GAP
   } mhb_dma_st_t;

   typedef struct packed {
      logic        cs_n;
      logic        rd_n;
      logic        wr_n;
      logic        ale;
      logic        cle;
   } mhb_strb_t;

   typedef struct packed {
      logic        wr;
      logic [7:0]  addr;
      logic [15:0] data;
   } mhb_acc_t;
endpackage : mhb_pkg

// ===== verilog/mhb_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and asynchronous active-low reset.
`timescale 1ns/1ns
module mhb_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input  wire logic             core_clk,  // Core clock
   input  wire logic             rstn,      // Async reset, active low
   input  wire logic [WIDTH-1:0] in_data,   // Fill data
   input  wire logic             in_valid,  // Fill valid
   output      logic             in_ready,  // Room available
   output      logic [WIDTH-1:0] out_data,  // Drain data
   output      logic             out_valid, // Data available
   input  wire logic             out_ready  // Drain accepts
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0]    wp_ff;
   logic [AW-1:0]    rp_ff;
   logic [AW:0]      cnt_ff;
   wire              push = in_valid && in_ready;
   wire              pop  = out_valid && out_ready;

   assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
   assign out_valid = (cnt_ff != '0);
   assign out_data  = mem_ff[rp_ff];

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         wp_ff  <= '0;
         rp_ff  <= '0;
         cnt_ff <= '0;
      end
      else
      begin
         if (push)
            wp_ff <= (wp_ff == AW'(DEPTH-1)) ? '0 : wp_ff + 1'b1;
         if (pop)
            rp_ff <= (rp_ff == AW'(DEPTH-1)) ? '0 : rp_ff + 1'b1;
         cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (push)
         mem_ff[wp_ff] <= in_data;
   end
endmodule : mhb_fifo

// ===== verilog/mhb_bus_if.sv
// Processor-facing multimode bus interface with single-channel DMA.
// Assumes bus pins synchronous to core_clk; register file lies outside.
//
// Overview of operation
// - Straps both high at first read: SRAM mode, 16-bit.
// - Width configuration bit set selects 8-bit, clear keeps 16-bit.
// - Address-latch strap high, command strap low: NOR mode, 16-bit.
// - Address-latch strap low, command strap high: multiplexed mode, 16-bit.
// - SRAM mode: address from dedicated lines, shared bus carries data only.
// - NOR mode: address on bus while select and valid low, latched rising.
// - NOR read: drive data while output enable low, end on select rise.
// - NOR write: store data when write strobe rises, end on select rise.
// - Multiplexed mode: address while latch strobe high, captured falling.
// - Multiplexed read: drive data while read low, end on select rise.
// - Multiplexed write: commit on write strobe rise, end on select rise.
// - Lock bit freezes the currently detected bus mode.
// - Default mode is SRAM at 16-bit until another is detected.
// - Raise DMA request to start a transfer over shared bus.
// - Acknowledge level routes each cycle to DMA or register access.
// - Latch and command straps ignored during DMA cycles.
// - DMA data moves only on rising edge of write or read.
// - One channel; request drops at burst end, rises at next.
// - Side buffer registers allow register access during DMA.
// - Burst of one cycle: request toggles around every DMA cycle.
// - Pulse transfer done when DMA completes or is terminated.
// - NOR mode has no DMA request or acknowledge.
`timescale 1ns/1ns
module mhb_bus_if #(
   parameter int DATA_W = mhb_pkg::DATA_W,
   parameter int ADDR_W = mhb_pkg::ADDR_W,
   parameter int DEPTH  = mhb_pkg::FIFO_DEPTH
) (
   input  wire logic              core_clk,      // Core clock, 20 MHz
   input  wire logic              rstn,          // Async reset, active low
   input  wire logic              chip_sel_n,    // Chip select
   input  wire logic              read_strobe_n, // Read / output enable
   input  wire logic              write_strobe_n,// Write strobe
   input  wire logic              addr_latch_sel,// Strap, ALE or valid_n
   input  wire logic              cmd_latch_sel, // Command strap
   input  wire logic [ADDR_W-1:0] addr_in,       // Dedicated address
   input  wire logic [DATA_W-1:0] bus_in,        // Shared bus input
   output      logic [DATA_W-1:0] bus_out,       // Shared bus output
   output      logic [DATA_W-1:0] bus_oe,        // Per-line drive enable
   input  wire logic              width8,        // Width configuration bit
   input  wire logic              mode_lock,     // Mode lock bit
   output      logic [1:0]        mode_bits,     // Detected mode readback
   output      logic              width8_act,    // Active width is 8-bit
   output      logic [ADDR_W-1:0] reg_addr,      // Register access address
   output      logic [DATA_W-1:0] reg_wdata,     // Register write data
   output      logic              reg_wr,        // Register write pulse
   output      logic              reg_rd,        // Register read pulse
   input  wire logic [DATA_W-1:0] reg_rdata,     // Register read data
   output      logic              side_sel,      // Side buffer access
   input  wire logic              dma_start,     // Start DMA transfer
   input  wire logic              dma_dir_wr,    // 1: memory to buffer
   input  wire logic              dma_abort,     // Terminate DMA
   input  wire logic [15:0]       session_len,   // Transfer length, cycles
   input  wire logic [15:0]       burst_len,     // Cycles per burst
   input  wire logic              dma_acknowledge,// DMA acknowledge
   output      logic              dma_request,   // DMA request
   output      logic              dma_busy,      // DMA in progress
   output      logic              transfer_done, // End of DMA pulse
   output      logic [DATA_W-1:0] buf_wdata,     // DMA data to buffer
   output      logic              buf_wvalid,    // Buffer data valid
   input  wire logic              buf_wready,    // Buffer accepts
   input  wire logic [DATA_W-1:0] buf_rdata,     // DMA data from buffer
   input  wire logic              buf_rvalid,    // Buffer data ready
   output      logic              buf_rready     // Taken from buffer
);
   mhb_pkg::mhb_mode_t   mode_ff;
   logic                 detected_ff;
   mhb_pkg::mhb_strb_t   prev_ff;
   mhb_pkg::mhb_strb_t   cur;
   logic [ADDR_W-1:0]    alat_ff;
   logic [DATA_W-1:0]    rdat_ff;
   logic [DATA_W-1:0]    ddat_ff;
   mhb_pkg::mhb_dma_st_t dst_ff;
   mhb_pkg::mhb_dma_st_t nxt_dst;
   logic [15:0]          left_ff;
   logic [15:0]          bcnt_ff;
   logic                 done_ff;
   logic                 dma_rd_ff;

   assign cur = '{chip_sel_n, read_strobe_n, write_strobe_n,
                  addr_latch_sel, cmd_latch_sel};

   wire is_nor  = (mode_ff == mhb_pkg::MHB_NOR);
   wire is_mux  = (mode_ff == mhb_pkg::MHB_MUX);
   wire is_sram = (mode_ff == mhb_pkg::MHB_SRAM);
   wire dma_cyc = dma_acknowledge && !is_nor;
   wire rd_fall = prev_ff.rd_n && !read_strobe_n && !chip_sel_n;
   wire rd_rise = !prev_ff.rd_n && read_strobe_n;
   wire wr_rise = !prev_ff.wr_n && write_strobe_n;
   wire cs_low  = !chip_sel_n;
   // Strap sampling only on register read, never in DMA, never after lock
   wire sample  = rd_fall && !detected_ff && !mode_lock
                  && !dma_cyc;
   wire adv_rise = is_nor && !prev_ff.ale && addr_latch_sel && cs_low;
   wire ale_fall = is_mux && prev_ff.ale && !addr_latch_sel;
   wire pio_go  = cs_low && !dma_cyc;

   mhb_pkg::mhb_mode_t strap_mode;
   assign strap_mode = (addr_latch_sel && cmd_latch_sel) ? mhb_pkg::MHB_SRAM :
                       (addr_latch_sel)  ? mhb_pkg::MHB_NOR :
                       (cmd_latch_sel)   ? mhb_pkg::MHB_MUX :
                                           mode_ff;

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         mode_ff     <= mhb_pkg::MHB_SRAM;
         detected_ff <= 1'b0;
         prev_ff     <= '1;
      end
      else
      begin
         prev_ff <= cur;
         if (sample)
         begin
            mode_ff     <= strap_mode;
            detected_ff <= 1'b1;
         end
      end
   end

   assign mode_bits  = mode_ff;
   assign width8_act = width8;

   // Address capture per mode
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         alat_ff <= '0;
      else if (adv_rise || ale_fall)
         alat_ff <= bus_in[ADDR_W-1:0];
   end

   assign reg_addr = is_sram ? addr_in : alat_ff;

   wire [DATA_W-1:0] wmask = width8 ? DATA_W'(16'h00ff) : '1;
   assign reg_wdata = bus_in & wmask;
   assign reg_wr    = pio_go && wr_rise
                      && !(is_nor && !read_strobe_n);
   assign reg_rd    = pio_go && rd_fall;
   assign side_sel  = dma_busy && pio_go;

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         rdat_ff <= '0;
      else if (reg_rd)
         rdat_ff <= reg_rdata;
      else if (dma_cyc && dma_rd_ff && !read_strobe_n && cs_low)
         rdat_ff <= ddat_ff;
   end

   // Drive while select and read strobe low; stop when select rises
   wire drive = cs_low && !read_strobe_n && write_strobe_n;
   wire [DATA_W-1:0] lane_en = width8 ? DATA_W'(16'h00ff) : '1;
   assign bus_oe  = drive ? lane_en : '0;
   assign bus_out = rdat_ff & lane_en;

   // DMA channel
   wire dcyc_done = dma_cyc && cs_low && (dma_rd_ff ? rd_rise : wr_rise);
   wire last_cyc  = dcyc_done && (left_ff == 16'h0001);
   wire burst_end = dcyc_done && (bcnt_ff == 16'h0001);

   always_comb
   begin
      nxt_dst = dst_ff;
      case (dst_ff)
         mhb_pkg::MHB_DMA_IDLE:
            if (dma_start && !is_nor && session_len != 16'h0000)
               nxt_dst = mhb_pkg::MHB_DMA_REQ;
         mhb_pkg::MHB_DMA_REQ:
            if (dma_abort || last_cyc)
               nxt_dst = mhb_pkg::MHB_DMA_IDLE;
            else if (burst_end)
               nxt_dst = mhb_pkg::MHB_DMA_GAP;
         mhb_pkg::MHB_DMA_GAP:
            if (dma_abort)
               nxt_dst = mhb_pkg::MHB_DMA_IDLE;
            else if (!dma_acknowledge)
               nxt_dst = mhb_pkg::MHB_DMA_REQ;
         default:
            nxt_dst = mhb_pkg::MHB_DMA_IDLE;
      endcase
   end

   wire [15:0] blen = (burst_len == 16'h0000) ? 16'(mhb_pkg::BURST_DEF)
                                               : burst_len;

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         dst_ff    <= mhb_pkg::MHB_DMA_IDLE;
         left_ff   <= mhb_pkg::LEN_RST;
         bcnt_ff   <= mhb_pkg::LEN_RST;
         done_ff   <= 1'b0;
         dma_rd_ff <= 1'b0;
      end
      else
      begin
         dst_ff  <= nxt_dst;
         done_ff <= (dst_ff != mhb_pkg::MHB_DMA_IDLE)
                    && (nxt_dst == mhb_pkg::MHB_DMA_IDLE);
         if (dst_ff == mhb_pkg::MHB_DMA_IDLE)
         begin
            left_ff   <= session_len;
            bcnt_ff   <= blen;
            dma_rd_ff <= !dma_dir_wr;
         end
         else if (dcyc_done)
         begin
            left_ff <= left_ff - 16'h0001;
            bcnt_ff <= burst_end ? blen : bcnt_ff - 16'h0001;
         end
      end
   end

   // Data toward the host comes from the buffer, held for the next read
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         ddat_ff <= '0;
      else if (buf_rready)
         ddat_ff <= buf_rdata;
   end

   logic have_ff;
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         have_ff <= 1'b0;
      else if (buf_rready)
         have_ff <= 1'b1;
      else if (dcyc_done && dma_rd_ff)
         have_ff <= 1'b0;
   end

   assign buf_rready = dma_busy && dma_rd_ff && buf_rvalid && !have_ff;

   // Inbound DMA words pass through the FIFO; full stalls the request
   logic fifo_in_ready;
   mhb_fifo #(
      .WIDTH (DATA_W),
      .DEPTH (DEPTH)
   ) u_fifo (
      .core_clk  (core_clk),
      .rstn      (rstn),
      .in_data   (bus_in & wmask),
      .in_valid  (dcyc_done && !dma_rd_ff),
      .in_ready  (fifo_in_ready),
      .out_data  (buf_wdata),
      .out_valid (buf_wvalid),
      .out_ready (buf_wready)
   );

   wire data_ok = dma_rd_ff ? have_ff : fifo_in_ready;
   assign dma_busy      = (dst_ff != mhb_pkg::MHB_DMA_IDLE);
   assign dma_request   = (dst_ff == mhb_pkg::MHB_DMA_REQ) && data_ok;
   assign transfer_done = done_ff;

   AST_NOR_NO_DMA: assert property (
      @(posedge core_clk) disable iff (!rstn)
      is_nor |-> !dma_request)
      else $error("DMA request raised in NOR mode");

   AST_DEFAULT_SRAM: assert property (
      @(posedge core_clk) disable iff (!rstn)
      !detected_ff |-> is_sram)
      else $error("Mode not SRAM before detection");

   AST_LOCK_HOLDS: assert property (
      @(posedge core_clk) disable iff (!rstn)
      mode_lock && $past(mode_lock) |-> $stable(mode_ff))
      else $error("Locked mode changed");

   AST_UPPER_FLOAT: assert property (
      @(posedge core_clk) disable iff (!rstn)
      width8 |-> bus_oe[DATA_W-1:8] == '0)
      else $error("Upper lines driven in 8-bit width");

   AST_DRIVE_END: assert property (
      @(posedge core_clk) disable iff (!rstn)
      chip_sel_n |-> bus_oe == '0)
      else $error("Bus driven with chip select high");

   AST_DONE_PULSE: assert property (
      @(posedge core_clk) disable iff (!rstn)
      dma_busy ##1 !dma_busy |-> transfer_done ##1 !transfer_done)
      else $error("Transfer done not a single pulse at end");

   AST_BURST_DROP: assert property (
      @(posedge core_clk) disable iff (!rstn)
      burst_end && !last_cyc && !dma_abort |=> !dma_request)
      else $error("Request held across burst end");

   AST_WRITE_ON_RISE: assert property (
      @(posedge core_clk) disable iff (!rstn)
      reg_wr |-> write_strobe_n && !$past(write_strobe_n))
      else $error("Write taken without strobe rise");

   AST_MUX_ADDR: assert property (
      @(posedge core_clk) disable iff (!rstn)
      ale_fall |=> reg_addr == $past(bus_in[ADDR_W-1:0]) || is_sram)
      else $error("Multiplexed address not captured at latch fall");

   AST_SRAM_ADDR: assert property (
      @(posedge core_clk) disable iff (!rstn)
      is_sram |-> reg_addr == addr_in)
      else $error("SRAM address not taken from dedicated lines");

   AST_NOR_ADDR: assert property (
      @(posedge core_clk) disable iff (!rstn)
      adv_rise |=> reg_addr == $past(bus_in[ADDR_W-1:0]) || !is_nor)
      else $error("NOR address not captured at valid rise");

   AST_DMA_NOT_REG: assert property (
      @(posedge core_clk) disable iff (!rstn)
      dma_cyc |-> !reg_wr && !reg_rd)
      else $error("Register access during DMA cycle");

   AST_DMA_NO_STRAP: assert property (
      @(posedge core_clk) disable iff (!rstn)
      dma_cyc |=> $stable(mode_ff))
      else $error("Mode changed by a DMA cycle");

   AST_DMA_ON_RISE: assert property (
      @(posedge core_clk) disable iff (!rstn)
      dcyc_done && !dma_rd_ff |-> write_strobe_n && !$past(write_strobe_n))
      else $error("DMA write data taken without strobe rise");

   AST_READ_DRIVE: assert property (
      @(posedge core_clk) disable iff (!rstn)
      !chip_sel_n && !read_strobe_n && write_strobe_n |-> bus_oe[7:0] == 8'hff)
      else $error("Read data not driven while read strobe low");

   AST_FULL_WIDTH: assert property (
      @(posedge core_clk) disable iff (!rstn)
      !width8 && bus_oe != '0 |-> bus_oe == '1)
      else $error("Partial drive in 16-bit width");

   AST_DONE_AFTER: assert property (
      @(posedge core_clk) disable iff (!rstn)
      transfer_done |-> !dma_busy && $past(dma_busy))
      else $error("Transfer done without a transfer ending");

   AST_SIDE_ROUTE: assert property (
      @(posedge core_clk) disable iff (!rstn)
      reg_wr && dma_busy |-> side_sel)
      else $error("Register write during DMA not routed to side buffer");

   AST_IDLE_QUIET: assert property (
      @(posedge core_clk) disable iff (!rstn)
      !dma_busy |-> !dma_request)
      else $error("DMA request raised while channel idle");
endmodule : mhb_bus_if

// ===== tb/mhb_host_model.sv
// Bus master model for the multimode host bus interface.
// Assumes the bench names the mode; pins move 5 ns after a clock rise.
`timescale 1ns/1ns
module mhb_host_model (
   input  wire logic               core_clk,    // Core clock
   input  wire mhb_pkg::mhb_mode_t bus_mode,    // Mode to speak
   output      logic               cs_n,        // Chip select
   output      logic               rd_n,        // Read strobe
   output      logic               wr_n,        // Write strobe
   output      logic               ale,         // Latch or valid strobe
   output      logic [7:0]         addr,        // Dedicated address
   output      logic [15:0]        bus,         // Shared bus drive
   output      logic               ack,         // DMA acknowledge
   input  wire logic [15:0]        bus_out,     // Device read data
   input  wire logic [15:0]        bus_oe,      // Device drive enables
   input  wire logic               dma_request  // Device request
);
   logic [15:0] oe_seen;

   initial
   begin
      {cs_n, rd_n, wr_n, ale, ack} = 5'b1_1110;
      addr = 8'h00;
      bus  = 16'h0000;
   end

   task automatic tick;
      @(posedge core_clk);
      #5;
   endtask : tick

   // Address phase, then one strobe; released bus shows the inverse
   task automatic access(input logic w, input logic [7:0] a,
                         input logic [15:0] d, output logic [15:0] q);
      tick;
      cs_n = 1'b0;
      addr = a;
      bus  = {8'h00, a};
      ale  = (bus_mode != mhb_pkg::MHB_NOR);
      repeat (2) tick;
      ale = (bus_mode != mhb_pkg::MHB_MUX);
      tick;  // Address still stands when the latch or valid edge is seen
      bus = w ? d : ~bus;
      tick;
      if (w)
         wr_n = 1'b0;  // Read strobe stays high
      else
         rd_n = 1'b0;  // Write strobe stays high
      repeat (3) tick;
      q = bus_out;
      oe_seen = bus_oe;
      rd_n = 1'b1;
      wr_n = 1'b1;
      tick;
      cs_n = 1'b1;
      bus  = ~bus;
   endtask : access

   task automatic dma_cycle(input logic w, input logic [15:0] d,
                            output logic [15:0] q, output logic r);
      int n;
      n = 0;
      while (dma_request !== 1'b1 && n < 200)
      begin
         tick;
         n++;
      end
      ack  = 1'b1;  // Held for the whole DMA cycle
      cs_n = 1'b0;
      ale  = ~ale;
      bus  = w ? d : ~bus;
      if (w)
         wr_n = 1'b0;
      else
         rd_n = 1'b0;
      repeat (3) tick;
      q = bus_out;
      rd_n = 1'b1;
      wr_n = 1'b1;
      repeat (2) tick;
      r    = dma_request;
      cs_n = 1'b1;
      ale  = ~ale;
      bus  = ~bus;
      tick;
      ack = 1'b0;  // Released after every cycle
   endtask : dma_cycle
endmodule : mhb_host_model

// ===== tb/tb.sv
// Self-checking bench for the multimode host bus interface.
// Assumes the host model, a local buffer stand-in and a 50 ns clock.
`timescale 1ns/1ns
module tb;
   logic core_clk, rstn, cmd_latch_sel, width8, mode_lock, dma_start;
   logic dma_dir_wr, dma_abort, chip_sel_n, read_strobe_n, write_strobe_n;
   logic addr_latch_sel, dma_acknowledge, reg_wr, reg_rd, side_sel;
   logic dma_request, dma_busy, transfer_done, width8_act, r, wr_side;
   logic buf_wvalid, buf_wready, buf_rvalid, buf_rready;
   logic [1:0]  mode_bits;
   logic [7:0]  addr_in, reg_addr, wr_addr;
   logic [15:0] bus_in, bus_out, bus_oe, reg_wdata, reg_rdata, wr_data, q;
   logic [15:0] session_len, burst_len, buf_wdata, buf_rdata;
   int          miscompares, checks, wr_cnt, done_cnt, cycles, w0;
   int          wr_idx, rd_idx;
   logic [15:0] store [8];
   mhb_pkg::mhb_mode_t mode;

   mhb_bus_if dut (.core_clk, .rstn, .chip_sel_n, .read_strobe_n,
      .write_strobe_n, .addr_latch_sel, .cmd_latch_sel, .addr_in, .bus_in,
      .bus_out, .bus_oe, .width8, .mode_lock, .mode_bits, .width8_act,
      .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .side_sel,
      .dma_start, .dma_dir_wr, .dma_abort, .session_len, .burst_len,
      .dma_acknowledge, .dma_request, .dma_busy, .transfer_done, .buf_wdata,
      .buf_wvalid, .buf_wready, .buf_rdata, .buf_rvalid, .buf_rready);
   mhb_host_model host (.core_clk, .bus_mode(mode), .cs_n(chip_sel_n),
      .rd_n(read_strobe_n), .wr_n(write_strobe_n), .ale(addr_latch_sel),
      .addr(addr_in), .bus(bus_in), .ack(dma_acknowledge), .bus_out,
      .bus_oe, .dma_request);

   // Register file stand-in: data is a function of the address
   assign reg_rdata = {~reg_addr, reg_addr};

   // Local buffer stand-in: takes eight words, hands them back in order
   assign buf_wready = (wr_idx < 8);
   assign buf_rvalid = (rd_idx < wr_idx);
   assign buf_rdata  = store[rd_idx[2:0]];

   always @(posedge core_clk)
   begin
      if (buf_wvalid === 1'b1 && buf_wready)
      begin
         store[wr_idx[2:0]] <= buf_wdata;
         wr_idx <= wr_idx + 1;
      end
      if (buf_rready === 1'b1 && buf_rvalid)
         rd_idx <= rd_idx + 1;
   end

   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   always @(posedge core_clk)
   begin
      cycles <= cycles + 1;
      if (transfer_done === 1'b1)
         done_cnt <= done_cnt + 1;
      if (reg_wr === 1'b1)
      begin
         wr_addr <= reg_addr;
         wr_data <= reg_wdata;
         wr_side <= side_sel;
         wr_cnt  <= wr_cnt + 1;
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic conclude;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : conclude

   task automatic restart(input int m);
      rstn = 1'b0;
      mode = mhb_pkg::mhb_mode_t'(m);
      cmd_latch_sel = (mode != mhb_pkg::MHB_NOR);
      repeat (3) host.tick;
      rstn = 1'b1;
      host.tick;
   endtask : restart

   task automatic start_dma(input logic w, input logic [15:0] l, b);
      dma_dir_wr  = w;
      session_len = l;
      burst_len   = b;
      dma_start   = 1'b1;
      host.tick;
      dma_start = 1'b0;
   endtask : start_dma

   initial
   begin
      {rstn, width8, mode_lock, dma_start, dma_abort, dma_dir_wr} = 6'h00;
      {session_len, burst_len} = 32'h0000_0000;
      {miscompares, checks, wr_cnt, done_cnt, cycles} = '0;
      restart(0);
      check({14'h0000, mode_bits}, 16'h0000);
      for (int i = 0; i < 3; i++)
      begin
         restart(i);
         host.access(1'b0, 8'h00, 16'h0000, q);
         check({14'h0000, mode_bits}, 16'(i));
         mode_lock = (i == 2);
         host.access(1'b0, 8'h3c, 16'h0000, q);
         check(q, 16'hc33c);
         check({14'h0000, mode_bits}, 16'(i));
         host.access(1'b1, 8'h5a, 16'hbeef, q);
         check({wr_addr, wr_data[7:0]}, 16'h5aef);
         width8 = 1'b1;
         host.access(1'b0, 8'h77, 16'h0000, q);
         check(host.oe_seen, 16'h00ff);
         check(q & 16'h00ff, 16'h0077);
         host.access(1'b1, 8'h21, 16'h1234, q);
         check(wr_data, 16'h0034);
         width8 = 1'b0;
         $display("test bus mode %0d done", i);
      end
      restart(1);
      host.access(1'b0, 8'h41, 16'h0000, q);
      check({14'h0000, mode_bits}, 16'h0000);
      check(q, 16'hbe41);
      mode_lock = 1'b0;
      $display("test lock done");
      restart(0);
      host.access(1'b0, 8'h00, 16'h0000, q);
      w0 = wr_cnt;
      start_dma(1'b1, 16'h0008, 16'h0001);
      for (int k = 0; k < 8; k++)
      begin
         host.dma_cycle(1'b1, 16'h1000 + 16'(k), q, r);
         check({15'h0000, r}, 16'h0000);
         if (k == 3)
         begin
            host.access(1'b1, 8'h9a, 16'h2222, q);
            check({15'h0000, wr_side}, 16'h0001);
         end
      end
      repeat (4) host.tick;
      check(16'(wr_cnt - w0), 16'h0001);
      check({14'h0000, buf_wvalid, dma_busy}, 16'h0000);
      check(16'(wr_idx), 16'h0008);
      check(16'(done_cnt), 16'h0001);
      start_dma(1'b0, 16'h0008, 16'h0004);
      for (int k = 0; k < 8; k++)
      begin
         host.dma_cycle(1'b0, 16'h0000, q, r);
         check(q, 16'h1000 + 16'(k));
         check({15'h0000, r}, 16'((k % 4) != 3));
      end
      repeat (4) host.tick;
      check(16'(rd_idx), 16'h0008);
      check(16'(done_cnt), 16'h0002);
      start_dma(1'b1, 16'h000a, 16'h0001);
      for (int k = 0; k < 8; k++)
         host.dma_cycle(1'b1, 16'h4321, q, r);
      repeat (2) host.tick;
      check({15'h0000, dma_request}, 16'h0000);
      dma_abort = 1'b1;
      host.tick;
      dma_abort = 1'b0;
      repeat (4) host.tick;
      check({14'h0000, dma_busy, dma_request}, 16'h0000);
      check(16'(done_cnt), 16'h0003);
      $display("test dma done");
      restart(1);
      host.access(1'b0, 8'h00, 16'h0000, q);
      start_dma(1'b1, 16'h0002, 16'h0001);
      repeat (10) host.tick;
      check({14'h0000, dma_busy, dma_request}, 16'h0000);
      $display("test nor dma done");
      conclude;
   end

   initial
   begin
      wait (cycles >= 5000);
      miscompares++;
      conclude;
   end
endmodule : tb
